/* File: logic/bbex_front.sv */
// logic: bit-band remap and exclusive access monitor
`timescale 1ns/10ps
// Summary of operation
// - alias write sets bit from data bit 0
// - alias write ignores data bits 31:1
// - alias read returns 0 or 1 only
// - byte lanes stored little-endian
// - load-exclusive returns data and sets tag
// - store-exclusive returns 0 done, 1 refused
// - exclusives in word, half and byte
// - clear-exclusive drops the tag
// - every store-exclusive drops the tag
// - exception taken drops the tag
// - alias offset is byte*32 plus bit*4
// - alias write is read-modify-write; no fetch remap
// - two 32 MB aliases over 1 MB bands
module bbex_front (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // request from the load/store pipeline
    input wire logic req_valid,
    input wire bbex_pkg::bbex_op_t req_op,
    input wire bbex_pkg::bbex_size_t req_size,
    input wire logic [31:0] req_addr,
    input wire logic [31:0] req_wdata,
    input wire logic req_fetch,
    input wire logic exception_taken,
    // answer to the pipeline
    output logic rsp_valid,
    output logic [31:0] rsp_rdata,
    output logic rsp_excl_status,
    output logic busy,
    output logic excl_tag,
    // memory side, one word per beat
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [3:0] mem_be,
    output logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata
);
    import bbex_pkg::*;

    // ******************************************************************
    // reset release
    // ******************************************************************
    logic rst_meta; // first stage, read only by the second
    logic rst_n; // released reset used everywhere
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ******************************************************************
    // alias decode
    // ******************************************************************
    logic in_sram_alias; // hit in sram alias window
    logic in_peri_alias; // hit in peripheral alias window
    logic is_alias; // data access to either alias
    logic [31:0] band_word; // word address of target bit
    logic [1:0] band_lane; // byte lane of target bit
    logic [BBEX_BIT_NUM_W-1:0] band_bit; // bit number inside byte
    logic [BBEX_BAND_BITS-1:0] byte_off; // byte offset in band
    assign in_sram_alias = (req_addr[31:BBEX_ALIAS_BITS] ==
        BBEX_SRAM_ALIAS_BASE[31:BBEX_ALIAS_BITS]);
    assign in_peri_alias = (req_addr[31:BBEX_ALIAS_BITS] ==
        BBEX_PERI_ALIAS_BASE[31:BBEX_ALIAS_BITS]);
    // fetches go straight through: remapping them would alias code
    assign is_alias = (in_sram_alias || in_peri_alias) && !req_fetch;
    assign byte_off = req_addr[BBEX_ALIAS_BITS-1:BBEX_BYTE_SHIFT];
    assign band_bit = req_addr[BBEX_BYTE_SHIFT-1:BBEX_BIT_SHIFT];
    assign band_lane = byte_off[1:0];
    assign band_word = (in_sram_alias ? BBEX_SRAM_BAND_BASE
        : BBEX_PERI_BAND_BASE) | {12'h000, byte_off[19:2], 2'b00};

    // ******************************************************************
    // lane placement, little-endian
    // ******************************************************************
    logic [3:0] lane_be; // byte enables for a direct access
    logic [31:0] lane_wdata; // store data moved onto its lanes
    always_comb begin
        case (req_size)
            BBEX_SZ_BYTE: begin
                lane_be = 4'b0001 << req_addr[1:0];
                lane_wdata = {4{req_wdata[7:0]}};
            end
            BBEX_SZ_HALF: begin
                lane_be = req_addr[1] ? 4'b1100 : 4'b0011;
                lane_wdata = {2{req_wdata[15:0]}};
            end
            default: begin
                lane_be = 4'b1111;
                lane_wdata = req_wdata;
            end
        endcase
    end

    // read data pulled back to bit 0 by size
    function automatic logic [31:0] bbex_extract(input logic [31:0] w,
        input logic [1:0] a, input bbex_size_t s);
        logic [31:0] sh;
        sh = w >> {a, 3'b000}; // lowest address is least significant
        case (s)
            BBEX_SZ_BYTE: bbex_extract = {24'h00_0000, sh[7:0]};
            BBEX_SZ_HALF: bbex_extract = {16'h0000, sh[15:0]};
            default: bbex_extract = w;
        endcase
    endfunction

    // ******************************************************************
    // access sequencer
    // ******************************************************************
    bbex_state_t state; // sequencer state
    logic hold_alias; // current access is alias
    logic hold_wbit; // alias write value, data bit 0
    logic [4:0] hold_bitpos; // target bit within word
    logic [1:0] hold_lo; // low address bits
    bbex_size_t hold_size; // access size
    bbex_op_t hold_op; // access operation
    logic start; // new access accepted
    logic excl_refused; // store-exclusive without tag
    logic is_write_op; // store or store-exclusive

    assign is_write_op = (req_op == BBEX_OP_STORE) ||
        (req_op == BBEX_OP_STORE_EXCL);
    assign start = ce && state == BBEX_ST_IDLE && req_valid &&
        req_op != BBEX_OP_CLEAR_EXCL;
    assign excl_refused = req_op == BBEX_OP_STORE_EXCL && !excl_tag;

    // state walk; alias writes read the word first
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= BBEX_ST_IDLE;
        end else if (ce) begin
            case (state)
                BBEX_ST_IDLE: begin
                    if (start && excl_refused) begin
                        state <= BBEX_ST_DONE;
                    end else if (start) begin
                        state <= (is_write_op && !is_alias) ?
                            BBEX_ST_WRITE : BBEX_ST_READ;
                    end
                end
                BBEX_ST_READ: begin
                    if (mem_ack) begin
                        state <= (hold_alias && hold_op != BBEX_OP_LOAD &&
                            hold_op != BBEX_OP_LOAD_EXCL) ?
                            BBEX_ST_WRITE : BBEX_ST_DONE;
                    end
                end
                BBEX_ST_WRITE: begin
                    if (mem_ack) begin
                        state <= BBEX_ST_DONE;
                    end
                end
                BBEX_ST_DONE: begin
                    state <= BBEX_ST_IDLE;
                end
                default: begin
                    state <= BBEX_ST_IDLE;
                end
            endcase
        end
    end

    // capture of the access being served
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_alias <= 1'b0;
            hold_wbit <= 1'b0;
            hold_bitpos <= 5'd0;
            hold_lo <= 2'b00;
            hold_size <= BBEX_SZ_WORD;
            hold_op <= BBEX_OP_LOAD;
        end else if (start) begin
            hold_alias <= is_alias;
            hold_wbit <= req_wdata[0];
            hold_bitpos <= {band_lane, band_bit};
            hold_lo <= req_addr[1:0];
            hold_size <= req_size;
            hold_op <= req_op;
        end
    end

    // ******************************************************************
    // memory port
    // ******************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= 32'h0000_0000;
            mem_be <= 4'h0;
            mem_wdata <= 32'h0000_0000;
        end else if (ce) begin
            if (start && !excl_refused) begin
                mem_req <= 1'b1;
                mem_we <= is_write_op && !is_alias;
                mem_addr <= is_alias ? band_word :
                    {req_addr[31:2], 2'b00};
                mem_be <= is_alias ? 4'b1111 : lane_be;
                mem_wdata <= lane_wdata;
            end else if (state == BBEX_ST_READ && mem_ack &&
                    hold_alias && hold_op != BBEX_OP_LOAD &&
                    hold_op != BBEX_OP_LOAD_EXCL) begin
                // second beat writes the word back, one bit changed
                mem_we <= 1'b1;
                mem_wdata <= hold_wbit ? (mem_rdata | (32'h0000_0001 <<
                    hold_bitpos)) : (mem_rdata & ~(32'h0000_0001 <<
                    hold_bitpos));
            end else if (mem_ack) begin
                mem_req <= 1'b0;
                mem_we <= 1'b0;
            end
        end
    end

    // ******************************************************************
    // answer to the pipeline
    // ******************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= 32'h0000_0000;
            rsp_excl_status <= BBEX_EXCL_OK;
        end else if (ce) begin
            rsp_valid <= state == BBEX_ST_DONE;
            if (start) begin
                rsp_excl_status <= excl_refused ?
                    BBEX_EXCL_FAIL : BBEX_EXCL_OK;
            end
            if (state == BBEX_ST_READ && mem_ack) begin
                if (hold_alias) begin
                    rsp_rdata <= mem_rdata[hold_bitpos] ?
                        BBEX_ALIAS_SET : BBEX_ALIAS_CLEAR;
                end else begin
                    rsp_rdata <= bbex_extract(mem_rdata, hold_lo,
                        hold_size);
                end
            end else if (start) begin
                rsp_rdata <= 32'h0000_0000;
            end
        end
    end

    // busy stands while an access is under way and falls as the answer appears
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
        end else if (ce) begin
            busy <= start || (state != BBEX_ST_IDLE &&
                state != BBEX_ST_DONE);
        end
    end

    // ******************************************************************
    // exclusive monitor
    // ******************************************************************
    // one local tag, no address compare: pairing is the requester's job
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            excl_tag <= 1'b0;
        end else if (ce) begin
            if (exception_taken) begin
                excl_tag <= 1'b0;
            end else if (state == BBEX_ST_IDLE && req_valid &&
                    req_op == BBEX_OP_CLEAR_EXCL) begin
                excl_tag <= 1'b0;
            end else if (start && req_op == BBEX_OP_STORE_EXCL) begin
                excl_tag <= 1'b0;
            end else if (start && req_op == BBEX_OP_LOAD_EXCL) begin
                excl_tag <= 1'b1;
            end
        end
    end

    // ******************************************************************
    // checks
    // ******************************************************************
    // start already carries ce, so a frozen cycle never matches
    sequence s_ld_excl;
        ce && start && req_op == BBEX_OP_LOAD_EXCL && !exception_taken;
    endsequence

    chk_load_sets_tag: assert property (@(posedge clk) disable iff (!rst_n)
        s_ld_excl |=> excl_tag)
        else $error("load-exclusive did not set tag");
    chk_clear_drops_tag: assert property (@(posedge clk)
        disable iff (!rst_n) ce && state == BBEX_ST_IDLE && req_valid &&
        req_op == BBEX_OP_CLEAR_EXCL |=> !excl_tag)
        else $error("clear-exclusive left tag set");
    chk_store_excl_word_drops_tag: assert property (@(posedge clk)
        disable iff (!rst_n) start && req_op == BBEX_OP_STORE_EXCL
        |=> !excl_tag)
        else $error("store-exclusive left tag set");
    chk_exc_drops_tag: assert property (@(posedge clk) disable iff (!rst_n)
        ce && exception_taken |=> !excl_tag)
        else $error("exception left tag set");
    chk_refused_no_write: assert property (@(posedge clk)
        disable iff (!rst_n) start && excl_refused |=> !mem_req ##1
        (rsp_valid && rsp_excl_status == BBEX_EXCL_FAIL))
        else $error("refused store-exclusive touched memory");
    chk_alias_read_bit: assert property (@(posedge clk) disable iff (!rst_n)
        rsp_valid && hold_alias |-> rsp_rdata[31:1] == 31'd0)
        else $error("alias read has upper bits");
    chk_alias_rmw_order: assert property (@(posedge clk)
        disable iff (!rst_n) mem_req && mem_we && hold_alias
        |-> $past(state) == BBEX_ST_READ || state == BBEX_ST_WRITE)
        else $error("alias write without prior read");
    chk_fetch_no_remap: assert property (@(posedge clk) disable iff (!rst_n)
        start && req_fetch |=> !hold_alias)
        else $error("fetch was remapped");
endmodule

/* File: pkg/bbex_pkg.sv */
// package: address map, access codes and states of the bit-band front end
package bbex_pkg;
    // ******************************************************************
    // address map
    // ******************************************************************
    localparam logic [31:0] BBEX_SRAM_BAND_BASE = 32'h2000_0000;
    localparam logic [31:0] BBEX_SRAM_ALIAS_BASE = 32'h2200_0000;
    localparam logic [31:0] BBEX_PERI_BAND_BASE = 32'h4000_0000;
    localparam logic [31:0] BBEX_PERI_ALIAS_BASE = 32'h4200_0000;
    // alias region spans 32 MB, bit-band region 1 MB
    localparam int BBEX_ALIAS_BITS = 25;
    localparam int BBEX_BAND_BITS = 20;
    // alias offset = byte_offset * 32 + bit_number * 4
    localparam int BBEX_BYTE_SHIFT = 5;
    localparam int BBEX_BIT_SHIFT = 2;
    localparam int BBEX_BIT_NUM_W = 3;

    // ******************************************************************
    // access sizes and operations
    // ******************************************************************
    typedef enum logic [1:0] {
        BBEX_SZ_BYTE = 2'b00,
        BBEX_SZ_HALF = 2'b01,
        BBEX_SZ_WORD = 2'b10
    } bbex_size_t;

    typedef enum logic [2:0] {
        BBEX_OP_LOAD = 3'b000,
        BBEX_OP_STORE = 3'b001,
        BBEX_OP_LOAD_EXCL = 3'b010,
        BBEX_OP_STORE_EXCL = 3'b011,
        BBEX_OP_CLEAR_EXCL = 3'b100
    } bbex_op_t;

    typedef enum logic [1:0] {
        BBEX_ST_IDLE = 2'b00,
        BBEX_ST_READ = 2'b01,
        BBEX_ST_WRITE = 2'b10,
        BBEX_ST_DONE = 2'b11
    } bbex_state_t;

    localparam logic [31:0] BBEX_ALIAS_CLEAR = 32'h0000_0000;
    localparam logic [31:0] BBEX_ALIAS_SET = 32'h0000_0001;
    localparam logic BBEX_EXCL_OK = 1'b0;
    localparam logic BBEX_EXCL_FAIL = 1'b1;
endpackage

/* File: sim/bbex_mem_model.sv */
// partner: word memory that answers the front end's beats
`timescale 1ns/10ps
module bbex_mem_model (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // wait states before each acknowledge
    input wire logic [3:0] lat,
    // beat from the front end
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [3:0] mem_be,
    input wire logic [31:0] mem_wdata,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    // ****************************************************************
    // storage
    // ****************************************************************
    logic [31:0] mem [0:63]; // two banks of 32 words, bank from bit 30
    logic [31:0] rd_q; // data of the last beat, read before its write
    logic [3:0] cnt; // wait states spent on this beat
    logic [5:0] idx; // word index of the beat
    assign idx = {mem_addr[30], mem_addr[6:2]};
    // off the acknowledge the bus shows the inverse, so stale data fails
    assign mem_rdata = mem_ack ? rd_q : ~rd_q;
    // one beat at a time; the acknowledge stands one cycle only
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mem_ack <= 1'b0;
            cnt <= 4'h0;
            rd_q <= 32'h0000_0000;
            for (int i = 0; i < 64; i++) begin
                mem[i] <= 32'h0000_0000;
            end
        end else if (mem_ack) begin
            // the beat seen now is the one just answered
            mem_ack <= 1'b0;
            cnt <= 4'h0;
        end else if (mem_req && cnt == lat) begin
            mem_ack <= 1'b1;
            rd_q <= mem[idx];
            for (int b = 0; b < 4; b++) begin
                if (mem_we && mem_be[b]) begin
                    mem[idx][8*b+:8] <= mem_wdata[8*b+:8];
                end
            end
        end else if (mem_req) begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule

/* File: sim/tb_bitband_exclusive_access.sv */
// testbench: bit-band remap, byte order and exclusive monitor
`timescale 1ns/10ps
module tb_bitband_exclusive_access;
    import bbex_pkg::*;
    // ****************************************************************
    // stimulus and observed signals
    // ****************************************************************
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1; // never frozen here
    logic req_valid = 1'b0;
    bbex_op_t req_op = BBEX_OP_LOAD;
    bbex_size_t req_size = BBEX_SZ_WORD;
    logic [31:0] req_addr = 32'h0000_0000;
    logic [31:0] req_wdata = 32'h0000_0000;
    logic req_fetch = 1'b0;
    logic exception_taken = 1'b0;
    logic [3:0] lat = 4'h0;
    logic rsp_valid, rsp_excl_status, busy, excl_tag;
    logic [31:0] rsp_rdata, mem_addr, mem_wdata, mem_rdata;
    logic mem_req, mem_we, mem_ack;
    logic [3:0] mem_be;
    logic [31:0] r_data, seen_addr; // answer and last acknowledged address
    logic r_stat;
    logic fetch_next = 1'b0; // applied with the next request
    logic [3:0] lat_next = 4'h0;
    int n_mismatch = 0;
    int comparisons = 0;
    always #10 clk = ~clk;
    always @(posedge clk) begin
        if (mem_ack === 1'b1) seen_addr <= mem_addr;
    end
    bbex_front bbex_front_inst (.clk(clk), .rstn(rstn), .ce(ce),
        .req_valid(req_valid), .req_op(req_op), .req_size(req_size),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_fetch(req_fetch),
        .exception_taken(exception_taken), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .rsp_excl_status(rsp_excl_status),
        .busy(busy), .excl_tag(excl_tag), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_be(mem_be), .mem_wdata(mem_wdata),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    bbex_mem_model bbex_mem_model_inst (.clk(clk), .rstn(rstn), .lat(lat),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));
    // ****************************************************************
    // report, compare and bus tasks
    // ****************************************************************
    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk32(input string nm, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, g);
        chk32(nm, {31'd0, e}, {31'd0, g});
    endtask
    // request held until taken, then answer waited for, both bounded
    task automatic req(input bbex_op_t op, input bbex_size_t sz,
        input logic [31:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk);
        lat <= lat_next;
        req_fetch <= fetch_next;
        req_op <= op;
        req_size <= sz;
        req_addr <= a;
        req_wdata <= wd;
        req_valid <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (busy !== 1'b1 && rsp_valid !== 1'b1 && n < 50);
        @(posedge clk);
        req_valid <= 1'b0;
        #1;
        while (rsp_valid !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 100) begin
            n_mismatch++;
            end_of_test();
        end
        r_data = rsp_rdata;
        r_stat = rsp_excl_status;
    endtask
    // clear-exclusive has no answer; the tag is looked at shortly after
    task automatic clr;
        @(posedge clk);
        req_op <= BBEX_OP_CLEAR_EXCL;
        req_valid <= 1'b1;
        @(posedge clk);
        req_valid <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk1("tag after clear", 1'b0, excl_tag);
    endtask
    task automatic exc;
        @(posedge clk);
        exception_taken <= 1'b1;
        @(posedge clk);
        exception_taken <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk1("tag after exception", 1'b0, excl_tag);
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_endian;
        req(BBEX_OP_STORE, BBEX_SZ_WORD, 32'h2000_0000, 32'h4433_2211);
        for (int i = 0; i < 4; i++) begin
            req(BBEX_OP_LOAD, BBEX_SZ_BYTE, 32'h2000_0000 + i, 32'h0);
            chk32("byte lane", 32'h0000_0011 * (i + 1), r_data);
        end
        req(BBEX_OP_LOAD, BBEX_SZ_HALF, 32'h2000_0002, 32'h0);
        chk32("upper half", 32'h0000_4433, r_data);
        req(BBEX_OP_STORE, BBEX_SZ_BYTE, 32'h2000_0005, 32'h0000_00AA);
        req(BBEX_OP_LOAD, BBEX_SZ_WORD, 32'h2000_0004, 32'h0);
        chk32("second word", 32'h0000_AA00, r_data);
    endtask
    // slow memory here, so the read-modify-write sees wait states
    task automatic t_alias;
        lat_next = 4'h3;
        req(BBEX_OP_STORE, BBEX_SZ_WORD, 32'h2200_002C, 32'h0000_00FF);
        chk32("band address", 32'h2000_0000, seen_addr);
        req(BBEX_OP_LOAD, BBEX_SZ_WORD, 32'h2000_0000, 32'h0);
        chk32("bit set", 32'h4433_2A11, r_data);
        req(BBEX_OP_LOAD, BBEX_SZ_WORD, 32'h2200_002C, 32'h0);
        chk32("alias set", BBEX_ALIAS_SET, r_data);
        req(BBEX_OP_STORE, BBEX_SZ_WORD, 32'h2200_002C, 32'hFFFF_FFFE);
        req(BBEX_OP_LOAD, BBEX_SZ_WORD, 32'h2000_0000, 32'h0);
        chk32("bit clear", 32'h4433_2211, r_data);
        req(BBEX_OP_LOAD, BBEX_SZ_WORD, 32'h2200_002C, 32'h0);
        chk32("alias clear", BBEX_ALIAS_CLEAR, r_data);
        req(BBEX_OP_STORE, BBEX_SZ_WORD, 32'h4200_021C, 32'h0000_0001);
        req(BBEX_OP_LOAD, BBEX_SZ_WORD, 32'h4000_0010, 32'h0);
        chk32("peripheral bit", 32'h0000_0080, r_data);
        lat_next = 4'h0;
    endtask
    task automatic t_fetch;
        fetch_next = 1'b1;
        req(BBEX_OP_LOAD, BBEX_SZ_WORD, 32'h2200_002C, 32'h0);
        chk32("fetch address", 32'h2200_002C, seen_addr);
        fetch_next = 1'b0;
    endtask
    task automatic t_excl;
        bbex_size_t sz [3] = '{BBEX_SZ_BYTE, BBEX_SZ_HALF, BBEX_SZ_WORD};
        logic [31:0] ad [3] = '{32'h2000_0009, 32'h2000_000A, 32'h2000_000C};
        logic [31:0] vl [3] = '{32'h0000_005A, 32'h0000_BEEF, 32'h1234_5678};
        for (int i = 0; i < 3; i++) begin
            req(BBEX_OP_LOAD_EXCL, sz[i], ad[i], 32'h0);
            chk32("exclusive load", 32'h0000_0000, r_data);
            chk1("tag set", 1'b1, excl_tag);
            req(BBEX_OP_STORE_EXCL, sz[i], ad[i], vl[i]);
            chk1("store status", BBEX_EXCL_OK, r_stat);
            chk1("tag after store", 1'b0, excl_tag);
            req(BBEX_OP_STORE_EXCL, sz[i], ad[i], 32'hFFFF_FFFF);
            chk1("refused status", BBEX_EXCL_FAIL, r_stat);
            req(BBEX_OP_LOAD, sz[i], ad[i], 32'h0);
            chk32("exclusive data", vl[i], r_data);
        end
    endtask
    // semaphore claim; the first try is broken by a clear-exclusive, the next by an exception
    task automatic t_claim;
        int tries;
        req(BBEX_OP_LOAD_EXCL, BBEX_SZ_WORD, 32'h2000_0010, 32'h0);
        clr();
        req(BBEX_OP_STORE_EXCL, BBEX_SZ_WORD, 32'h2000_0010, 32'h1);
        chk1("status after clear", BBEX_EXCL_FAIL, r_stat);
        tries = 0;
        do begin
            tries++;
            req(BBEX_OP_LOAD_EXCL, BBEX_SZ_WORD, 32'h2000_0010, 32'h0);
            if (r_data === 32'h0000_0000) begin
                if (tries == 1) exc();
                req(BBEX_OP_STORE_EXCL, BBEX_SZ_WORD, 32'h2000_0010,
                    32'h1);
            end
        end while (r_stat !== BBEX_EXCL_OK && tries < 4);
        chk32("claim tries", 32'd2, 32'(tries));
        req(BBEX_OP_LOAD, BBEX_SZ_WORD, 32'h2000_0010, 32'h0);
        chk32("semaphore", 32'h0000_0001, r_data);
    endtask
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        t_endian();
        t_alias();
        t_fetch();
        t_excl();
        t_claim();
        end_of_test();
    end
endmodule
